// ---- rtl/swcan_mode_logic.sv ----
// mode, transmit and receive control of a single-wire bus transceiver
`timescale 1ns/1ps
module swcan_mode_logic
  import swcan_pkg::*;
#(
  parameter int TOUT_CYCLES  = TOUT_CYC,
  parameter int WUF_CYCLES   = WUF_CYC,
  parameter int SLEEP_CYCLES = SLEEP_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic txd_i,
  input  wire logic txd_driven_i,
  input  wire logic mode_select_a_i,
  input  wire logic mode_select_a_driven_i,
  input  wire logic mode_select_b_i,
  input  wire logic mode_select_b_driven_i,
  input  wire logic bus_dominant_i,
  input  wire logic high_voltage_wakeup_i,
  input  wire logic loss_of_ground_i,
  input  wire logic low_battery_i,
  output logic      bus_line_output_o,
  output logic      bus_high_voltage_o,
  output logic      wave_shaping_o,
  output logic      rxd_o,
  output logic      rxd_oe_o,
  output logic      load_ground_o,
  output logic      inhibit_o
);
  import swcan_pkg::*;

  // ==========================================================
  // reset release
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // state record
  typedef struct packed {
    logic             txd_prev;
    logic             tout;
    logic [CNT_W-1:0] tout_cnt;
    logic [CNT_W-1:0] wuf_cnt;
    logic [CNT_W-1:0] slp_cnt;
    logic [1:0]       mode;
    op_state_t        st;
    logic             wake_irq;
    logic             drv;
    logic             hv;
    logic             shape;
    logic             rxd;
    logic             rxd_oe;
    logic             load_gnd;
    logic             inh;
  } state_t;

  state_t cur;
  state_t next_cur;

  // pull resistors: an undriven pin reads as its default level
  logic txd_pin;
  logic ma_pin;
  logic mb_pin;
  logic txd_sync;
  logic ma_sync;
  logic mb_sync;
  logic bus_sync;
  logic hvw_sync;
  logic log_sync;

  swcan_pin_pull #(.IDLE_LEVEL(1'b1)) pull_txd (
    .pin_i   (txd_i),
    .driven_i(txd_driven_i),
    .level_o (txd_pin)
  );

  swcan_pin_pull #(.IDLE_LEVEL(1'b0)) pull_ma (
    .pin_i   (mode_select_a_i),
    .driven_i(mode_select_a_driven_i),
    .level_o (ma_pin)
  );

  swcan_pin_pull #(.IDLE_LEVEL(1'b0)) pull_mb (
    .pin_i   (mode_select_b_i),
    .driven_i(mode_select_b_driven_i),
    .level_o (mb_pin)
  );

  // ==========================================================
  // synchronisers; transmit resets recessive so no false edge
  swcan_sync2 #(.RESET_VAL(1'b1)) sync_txd (
    .sys_clk_i(sys_clk_i),
    .rst_n_i  (rst_n),
    .d_i      (txd_pin),
    .q_o      (txd_sync)
  );

  swcan_sync2 #(.RESET_VAL(1'b0)) sync_ma (
    .sys_clk_i(sys_clk_i),
    .rst_n_i  (rst_n),
    .d_i      (ma_pin),
    .q_o      (ma_sync)
  );

  swcan_sync2 #(.RESET_VAL(1'b0)) sync_mb (
    .sys_clk_i(sys_clk_i),
    .rst_n_i  (rst_n),
    .d_i      (mb_pin),
    .q_o      (mb_sync)
  );

  swcan_sync2 #(.RESET_VAL(1'b0)) sync_bus (
    .sys_clk_i(sys_clk_i),
    .rst_n_i  (rst_n),
    .d_i      (bus_dominant_i),
    .q_o      (bus_sync)
  );

  swcan_sync2 #(.RESET_VAL(1'b0)) sync_hvw (
    .sys_clk_i(sys_clk_i),
    .rst_n_i  (rst_n),
    .d_i      (high_voltage_wakeup_i),
    .q_o      (hvw_sync)
  );

  // loss of ground is slow, two extra cycles cost nothing
  swcan_sync2 #(.RESET_VAL(1'b0)) sync_log (
    .sys_clk_i(sys_clk_i),
    .rst_n_i  (rst_n),
    .d_i      (loss_of_ground_i),
    .q_o      (log_sync)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic             txd_s;
    logic [1:0]       mode_s;
    logic             bus_s;
    logic             hvw_s;
    logic             log_s;
    logic             wake_ok;
    logic             active;
    txd_s   = 1'b1;
    mode_s  = MODE_SLEEP;
    bus_s   = 1'b0;
    hvw_s   = 1'b0;
    log_s   = 1'b0;
    wake_ok = 1'b0;
    active  = 1'b0;
    next_cur = cur;

    txd_s  = txd_sync;
    mode_s = {mb_sync, ma_sync};
    bus_s  = bus_sync;
    hvw_s  = hvw_sync;
    log_s  = log_sync;
    next_cur.txd_prev = txd_s;
    next_cur.mode     = mode_s;

    // wake-up filter, counts persisting high-voltage activity
    if (hvw_s && cur.wuf_cnt < CNT_W'(WUF_CYCLES)) begin
      next_cur.wuf_cnt = cur.wuf_cnt + CNT_W'(1);
    end else if (!hvw_s) begin
      next_cur.wuf_cnt = '0;
    end
    wake_ok = hvw_s && (cur.wuf_cnt >= CNT_W'(WUF_CYCLES) - CNT_W'(1));

    // operating state
    unique case (cur.st)
      ST_SLEEP: begin
        next_cur.slp_cnt = '0;
        if (mode_s != MODE_SLEEP) begin
          next_cur.st = ST_ACTIVE;
        end else if (wake_ok) begin
          next_cur.st       = ST_STANDBY;
          next_cur.wake_irq = 1'b1;
        end
      end
      ST_STANDBY: begin
        if (mode_s != MODE_SLEEP) begin
          next_cur.st       = ST_ACTIVE;
          next_cur.wake_irq = 1'b0;
        end else if (cur.slp_cnt >= CNT_W'(SLEEP_CYCLES) - CNT_W'(1)) begin
          next_cur.st       = ST_SLEEP;
          next_cur.wake_irq = 1'b0;
        end else begin
          next_cur.slp_cnt = cur.slp_cnt + CNT_W'(1);
        end
      end
      ST_ACTIVE: begin
        next_cur.wake_irq = 1'b0;
        if (mode_s == MODE_SLEEP) begin
          next_cur.st = ST_SLEEP;
        end
      end
      default: begin
        next_cur.st = ST_SLEEP;
      end
    endcase
    active = (cur.st == ST_ACTIVE) && (mode_s != MODE_SLEEP);

    // stuck-dominant timeout, same figure in all active modes
    if (txd_s) begin
      next_cur.tout_cnt = '0;
      if (!cur.txd_prev) begin
        next_cur.tout = 1'b0;
      end
    end else if (cur.tout_cnt >= CNT_W'(TOUT_CYCLES) - CNT_W'(1)) begin
      next_cur.tout = 1'b1;
    end else begin
      next_cur.tout_cnt = cur.tout_cnt + CNT_W'(1);
    end

    // driver: mode changes take effect within a few cycles
    next_cur.drv   = active && !txd_s && !next_cur.tout;
    // high level only qualifies a dominant bit, never an idle bus
    next_cur.hv    = next_cur.drv && mode_s == MODE_WAKEUP &&
                     !low_battery_i;
    next_cur.shape = !(mode_s == MODE_HSPEED);

    // receive path
    if (cur.st == ST_SLEEP) begin
      next_cur.rxd    = 1'b1;
      next_cur.rxd_oe = 1'b0;
    end else if (cur.wake_irq || next_cur.wake_irq) begin
      next_cur.rxd    = 1'b0;
      next_cur.rxd_oe = 1'b1;
    end else begin
      next_cur.rxd    = !bus_s;
      next_cur.rxd_oe = 1'b1;
    end
    if (next_cur.st == ST_SLEEP) begin
      next_cur.rxd_oe = 1'b0;
    end

    next_cur.load_gnd = !log_s;
    next_cur.inh      = next_cur.st != ST_SLEEP;
  end

  // ==========================================================
  // registers; power-on state is sleep with driver off
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur          <= '0;
      cur.txd_prev <= 1'b1;
      cur.st       <= ST_SLEEP;
      cur.rxd      <= 1'b1;
      cur.shape    <= 1'b1;
      cur.load_gnd <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign bus_line_output_o  = cur.drv;
  assign bus_high_voltage_o = cur.hv;
  assign wave_shaping_o     = cur.shape;
  assign rxd_o              = cur.rxd;
  assign rxd_oe_o           = cur.rxd_oe;
  assign load_ground_o      = cur.load_gnd;
  assign inhibit_o          = cur.inh;
endmodule

// ==========================================================
// two-stage synchroniser; only stage two is read outside
module swcan_sync2
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  always_comb begin
    next_cur        = cur;
    next_cur.stage1 = d_i;
    next_cur.stage2 = cur.stage1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur.stage1 <= RESET_VAL;
      cur.stage2 <= RESET_VAL;
    end else begin
      cur <= next_cur;
    end
  end

  assign q_o = cur.stage2;
endmodule

// ==========================================================
// pin pull resistor: a floating pin reads its idle level
module swcan_pin_pull
#(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic pin_i,
  input  wire logic driven_i,
  output logic      level_o
);
  assign level_o = driven_i ? pin_i : IDLE_LEVEL;
endmodule

// ---- rtl/swcan_pkg.sv ----
// constants and types shared by the single-wire bus mode logic
package swcan_pkg;
  // ==========================================================
  // mode pin encodings (select_b, select_a)
  localparam logic [1:0] MODE_SLEEP  = 2'h0;
  localparam logic [1:0] MODE_HSPEED = 2'h1;
  localparam logic [1:0] MODE_WAKEUP = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  // ==========================================================
  // timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int TOUT_MS        = 17;
  localparam int WUF_MIN_US     = 10;
  localparam int WUF_MAX_US     = 70;
  localparam int WUF_US         = 40;
  localparam int SLEEP_TOUT_MS  = 250;
  localparam int MODE_SW_MAX_MS = 30;
  localparam int TOUT_CYC       = TOUT_MS * (CLK_HZ / 1000);
  localparam int WUF_CYC        = WUF_US * (CLK_HZ / 1_000_000);
  localparam int SLEEP_CYC      = SLEEP_TOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W          = 32;
  // ==========================================================
  // operating state, gray coded along sleep -> standby -> active
  typedef enum logic [1:0] {
    ST_SLEEP   = 2'b00,
    ST_STANDBY = 2'b01,
    ST_ACTIVE  = 2'b11
  } op_state_t;
endpackage

// ---- test/single_wire_can_mode_logic_test.sv ----
// self-checking bench for the single-wire bus mode logic
`timescale 1ns/1ps
module single_wire_can_mode_logic_test;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic txd_i = 1'b1;
  logic txd_driven_i = 1'b1;
  logic mode_select_a_i = 1'b0;
  logic mode_select_b_i = 1'b0;
  logic mode_select_a_driven_i = 1'b1;
  logic mode_select_b_driven_i = 1'b1;
  logic loss_of_ground_i = 1'b0;
  logic low_battery_i = 1'b0;
  logic o_dom = 1'b0;
  logic o_hv = 1'b0;
  logic bus_dominant_i, high_voltage_wakeup_i, bus_line_output_o;
  logic bus_high_voltage_o, wave_shaping_o, rxd_o, rxd_oe_o;
  logic load_ground_o, inhibit_o;
  int   fail_count = 0;
  int   num_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  swcan_mode_logic #(.TOUT_CYCLES(50), .WUF_CYCLES(8), .SLEEP_CYCLES(100))
    DUT (.sys_clk_i, .arst_n_i, .txd_i, .txd_driven_i, .mode_select_a_i,
    .mode_select_a_driven_i, .mode_select_b_i, .mode_select_b_driven_i,
    .bus_dominant_i, .high_voltage_wakeup_i, .loss_of_ground_i,
    .low_battery_i, .bus_line_output_o, .bus_high_voltage_o,
    .wave_shaping_o, .rxd_o, .rxd_oe_o, .load_ground_o, .inhibit_o);
  swcan_bus_model bus (.drive_i(bus_line_output_o), .hv_i(bus_high_voltage_o),
    .other_dom_i(o_dom), .other_hv_i(o_hv), .dom_o(bus_dominant_i),
    .hv_level_o(high_voltage_wakeup_i));
  // ====================================
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic tx(input logic v);
    @(posedge sys_clk_i);
    txd_i <= v;
  endtask
  task automatic set_mode(input logic a, input logic b);
    @(posedge sys_clk_i);
    mode_select_a_i <= a;
    mode_select_b_i <= b;
    settle(10);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ====================================
  task automatic t_sleep;
    settle(5);
    chk(bus_line_output_o, 1'b0);
    chk(load_ground_o, 1'b1);
    tx(1'b0);
    o_dom <= 1'b1;
    settle(10);
    chk(bus_line_output_o, 1'b0);
    chk(rxd_oe_o, 1'b0);
    tx(1'b1);
    o_dom <= 1'b0;
    $display("t_sleep done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      set_mode(m[0], m[1]);
      tx(1'b0);
      settle(8);
      chk(bus_line_output_o, m != 0);
      chk(bus_high_voltage_o, m == 2);
      chk(wave_shaping_o, m != 1);
      if (m != 0) chk(rxd_o, 1'b0);
      tx(1'b1);
      settle(8);
      chk(bus_line_output_o, 1'b0);
      if (m != 0) chk(rxd_o, 1'b1);
    end
    $display("t_modes done");
  endtask
  task automatic t_drive;
    tx(1'b0);
    txd_driven_i <= 1'b0;
    settle(8);
    chk(bus_line_output_o, 1'b0);
    @(posedge sys_clk_i);
    txd_driven_i <= 1'b1;
    settle(20);
    chk(bus_line_output_o, 1'b1);
    settle(50);
    chk(bus_line_output_o, 1'b0);
    tx(1'b1);
    tx(1'b0);
    settle(8);
    chk(bus_line_output_o, 1'b1);
    tx(1'b1);
    set_mode(1'b0, 1'b1);
    tx(1'b0);
    low_battery_i <= 1'b1;
    settle(8);
    chk(bus_line_output_o, 1'b1);
    chk(bus_high_voltage_o, 1'b0);
    tx(1'b1);
    low_battery_i <= 1'b0;
    $display("t_drive done");
  endtask
  task automatic t_wake;
    set_mode(1'b0, 1'b0);
    for (int i = 0; i < 200 && inhibit_o !== 1'b0; i++) settle(0);
    @(posedge sys_clk_i);
    o_hv <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    o_hv <= 1'b0;
    settle(10);
    chk(inhibit_o, 1'b0);
    @(posedge sys_clk_i);
    o_hv <= 1'b1;
    settle(20);
    chk(inhibit_o, 1'b1);
    chk(rxd_oe_o, 1'b1);
    chk(rxd_o, 1'b0);
    @(posedge sys_clk_i);
    o_hv <= 1'b0;
    settle(130);
    chk(inhibit_o, 1'b0);
    chk(rxd_oe_o, 1'b0);
    @(posedge sys_clk_i);
    loss_of_ground_i <= 1'b1;
    settle(5);
    chk(load_ground_o, 1'b0);
    @(posedge sys_clk_i);
    loss_of_ground_i <= 1'b0;
    settle(5);
    chk(load_ground_o, 1'b1);
    set_mode(1'b1, 1'b1);
    chk(inhibit_o, 1'b1);
    chk(rxd_oe_o, 1'b1);
    $display("t_wake done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    t_sleep();
    t_modes();
    t_drive();
    t_wake();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    end_sim();
  end
endmodule

// ---- test/swcan_bus_model.sv ----
// far-side bus model: wired-or of this driver and other nodes
`timescale 1ns/1ps
module swcan_bus_model (
  input  wire logic drive_i,
  input  wire logic hv_i,
  input  wire logic other_dom_i,
  input  wire logic other_hv_i,
  output logic      dom_o,
  output logic      hv_level_o
);
  // released bus falls to its low recessive level
  assign dom_o      = drive_i | other_dom_i;
  assign hv_level_o = (drive_i & hv_i) | other_hv_i;
endmodule

// ---- test/swcan_mode_logic_chk.sv ----
// assertion checker for the mode logic ports
`timescale 1ns/1ps
module swcan_mode_logic_chk #(
  parameter int TOUT_CYCLES = 50
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic txd_i,
  input wire logic txd_driven_i,
  input wire logic loss_of_ground_i,
  input wire logic low_battery_i,
  input wire logic bus_line_output_o,
  input wire logic bus_high_voltage_o,
  input wire logic rxd_oe_o,
  input wire logic load_ground_o,
  input wire logic inhibit_o
);
  // ====================================
  // dominant-request run length; slack of 8 covers sync latency
  int unsigned lo_cnt;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_cnt <= 0;
    end else begin
      lo_cnt <= (txd_driven_i && !txd_i) ? lo_cnt + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_SLEEP_QUIET: assert property (
    !inhibit_o |-> !bus_line_output_o) else $error("bus driven asleep");
  AST_TXD_HIGH_OFF: assert property (
    (txd_driven_i && txd_i)[*6] |-> !bus_line_output_o)
    else $error("bus driven on high transmit");
  AST_TXD_FLOAT_OFF: assert property (
    (!txd_driven_i)[*6] |-> !bus_line_output_o)
    else $error("bus driven on floating transmit");
  AST_RXD_OFF: assert property (
    !inhibit_o && !$past(inhibit_o) |-> !rxd_oe_o)
    else $error("receive driven asleep");
  AST_LOAD_GND: assert property (
    $stable(loss_of_ground_i)[*5] |-> load_ground_o != loss_of_ground_i)
    else $error("load ground wrong");
  AST_LOWBAT_NO_HV: assert property (
    low_battery_i[*5] |-> !bus_high_voltage_o)
    else $error("high level on low battery");
  AST_HV_WITH_DRIVE: assert property (
    bus_high_voltage_o |-> bus_line_output_o)
    else $error("high level without drive");
  AST_TIMEOUT: assert property (
    lo_cnt > TOUT_CYCLES + 8 |-> !bus_line_output_o)
    else $error("stuck dominant not cut");
endmodule
bind swcan_mode_logic swcan_mode_logic_chk #(.TOUT_CYCLES(TOUT_CYCLES)) chk (
  .sys_clk_i, .arst_n_i, .txd_i, .txd_driven_i, .loss_of_ground_i,
  .low_battery_i, .bus_line_output_o, .bus_high_voltage_o, .rxd_oe_o,
  .load_ground_o, .inhibit_o);
